/* File: inc/servo_mode_defines.svh */
`ifndef SERVO_MODE_DEFINES_SVH
`define SERVO_MODE_DEFINES_SVH

`define MODE_POS_SPEED 3'h3
`define MODE_POS_TORQUE 3'h4
`define MODE_SPEED_TORQUE 3'h5
`define MODE_EXTENSION 3'h6
`define MODE_FIXED_POS 3'h0
`define MODE_FIXED_SPEED 3'h1
`define MODE_FIXED_TORQUE 3'h2
`define OVR_W0_DEFAULT 8'h0A
`define OVR_W1_DEFAULT 8'h14
`define OVR_W2_DEFAULT 8'h28
`define OVR_W3_DEFAULT 8'h50
`define OVR_MAX_PCT 8'h96
`define OVR_FULL_PCT 8'h64
`define COUNTS_PER_PULSE 8'h10
`define TORQUE_FULL_MV 16'h0BB8
`define TORQUE_FULL_PCT 8'h64

`endif

/* File: inc/servo_mode_pkg.sv */
package servo_mode_pkg;

  typedef enum logic [1:0] {
    CTRL_POSITION = 2'b00,
    CTRL_SPEED = 2'b01,
    CTRL_TORQUE = 2'b10
  } ctrl_mode_t;

  typedef struct packed {
    logic mode_switch;
    logic position_request;
    logic torque_request;
    logic pulse_ratio_1;
    logic pulse_ratio_2;
    logic forward_command;
    logic reverse_command;
    logic override_enable;
    logic [3:0] override_bits;
  } seq_inputs_t;

  typedef struct packed {
    logic [7:0] w3;
    logic [7:0] w2;
    logic [7:0] w1;
    logic [7:0] w0;
  } override_weights_t;

endpackage

/* File: hdl/override_scaler.sv */
`timescale 1ns/1ps
`include "servo_mode_defines.svh"

module override_scaler #(
  parameter int SPEED_W = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire servo_mode_pkg::override_weights_t weights_in,
  input wire logic [3:0] bits_in,
  input wire logic enable_in,
  input wire logic bypass_in,
  input wire logic [SPEED_W-1:0] speed_in,
  input wire logic [SPEED_W-1:0] max_speed_in,
  input wire logic clamp_in,
  output logic [7:0] percent_out,
  output logic [SPEED_W-1:0] speed_out
);

  // ==========================================================
  // Weight sum with last valid value kept.
  logic [7:0] weight_sum;
  logic [7:0] next_weight_sum;
  logic [9:0] raw_sum;
  logic [7:0] wsel [4];
  logic [7:0] active_pct;
  logic [SPEED_W+7:0] product;
  logic [SPEED_W+7:0] scaled;
  logic [SPEED_W-1:0] limited;

  assign wsel[0] = bits_in[0] ? weights_in.w0 : 8'h00;
  assign wsel[1] = bits_in[1] ? weights_in.w1 : 8'h00;
  assign wsel[2] = bits_in[2] ? weights_in.w2 : 8'h00;
  assign wsel[3] = bits_in[3] ? weights_in.w3 : 8'h00;
  assign raw_sum = {2'b00, wsel[0]} + {2'b00, wsel[1]} + {2'b00, wsel[2]} + {2'b00, wsel[3]};
  assign next_weight_sum = (raw_sum > {2'b00, `OVR_MAX_PCT}) ? weight_sum : raw_sum[7:0];

  // ==========================================================
  // Speed scaling and clamp.
  assign active_pct = (enable_in && !bypass_in) ? weight_sum : `OVR_FULL_PCT;
  assign product = speed_in * active_pct;
  assign scaled = product / `OVR_FULL_PCT;
  assign limited = (clamp_in && scaled > {8'h00, max_speed_in}) ? max_speed_in
                   : scaled[SPEED_W-1:0];

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      weight_sum <= 8'h00;
      percent_out <= `OVR_FULL_PCT;
      speed_out <= '0;
    end else if (clk_en_in) begin
      weight_sum <= next_weight_sum;
      percent_out <= active_pct;
      speed_out <= limited;
    end
  end

endmodule // override_scaler

/* File: hdl/servo_mode_select_override.sv */
`timescale 1ns/1ps
`include "servo_mode_defines.svh"

// Behaviour
// - Mode switch honoured only for parameter 3-5.
// - Switch off/on picks mode pair per parameter.
// - Unassigned function inputs read as off.
// - Position request in mode 6 holds position unless torque request is also on.
// - Held position control allows pulse positioning.
// - Pulses need position request plus ratio select.
// - Default gearing gives sixteen counts per pulse for each unit of the selected ratio.
// - Torque request in mode 6 holds torque.
// - Torque produced only with forward or reverse.
// - Forward or reverse, with reference sign, sets torque direction.
// - Three volts reference equals rated torque.
// - Speed limit source picked by parameter.
// - Override enable scales speed by weight sum.
// - Override off means full commanded speed.
// - Percentage sums weights of active bits.
// - Weight sum above 150 keeps previous value.
// - Scaled speed never exceeds maximum speed outside pulse operation.
// - Override skips command pulse operation.
// - Max speed clamp skips pulse operation.
// - Ratio select 1 wins over select 2.
module servo_mode_select_override #(
  parameter int SPEED_W = 16,
  parameter int RATIO_W = 8,
  parameter logic [7:0] COUNTS_PER_PULSE = `COUNTS_PER_PULSE
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire servo_mode_pkg::seq_inputs_t seq_in,
  input wire servo_mode_pkg::seq_inputs_t assigned_in,
  input wire logic [2:0] control_mode_param_in,
  input wire servo_mode_pkg::override_weights_t weights_in,
  input wire logic [RATIO_W-1:0] pulse_ratio_first_in,
  input wire logic [RATIO_W-1:0] pulse_ratio_second_in,
  input wire logic command_pulse_in,
  input wire logic [SPEED_W-1:0] speed_command_in,
  input wire logic [SPEED_W-1:0] max_speed_pos_speed_mode_in,
  input wire logic torque_speed_limit_source_in,
  input wire logic [SPEED_W-1:0] speed_reference_in,
  input wire logic [SPEED_W-1:0] multi_step_speed_in,
  input wire logic [15:0] torque_reference_mv_in,
  input wire logic torque_reference_neg_in,
  output servo_mode_pkg::ctrl_mode_t ctrl_mode_out,
  output logic pulse_enable_out,
  output logic pulse_positioning_out,
  output logic [RATIO_W-1:0] pulse_ratio_out,
  output logic [31:0] position_count_out,
  output logic torque_active_out,
  output logic torque_reverse_out,
  output logic [7:0] torque_percent_out,
  output logic [SPEED_W-1:0] torque_speed_limit_out,
  output logic [7:0] override_percent_out,
  output logic [SPEED_W-1:0] speed_out
);

  // ==========================================================
  // Input sampling.
  servo_mode_pkg::seq_inputs_t seq;
  servo_mode_pkg::seq_inputs_t masked;

  assign masked = seq_in & assigned_in;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seq <= '0;
    end else if (clk_en_in) begin
      seq <= masked;
    end
  end

  // ==========================================================
  // Control mode decode.
  servo_mode_pkg::ctrl_mode_t next_mode;
  logic ext_mode;
  logic pulse_ok;
  logic pulse_ratio_active;

  assign ext_mode = (control_mode_param_in == `MODE_EXTENSION);

  always_comb begin
    next_mode = servo_mode_pkg::CTRL_POSITION;
    case (control_mode_param_in)
      `MODE_POS_SPEED: begin
        next_mode = seq.mode_switch ? servo_mode_pkg::CTRL_SPEED
                    : servo_mode_pkg::CTRL_POSITION;
      end
      `MODE_POS_TORQUE: begin
        next_mode = seq.mode_switch ? servo_mode_pkg::CTRL_TORQUE
                    : servo_mode_pkg::CTRL_POSITION;
      end
      `MODE_SPEED_TORQUE: begin
        next_mode = seq.mode_switch ? servo_mode_pkg::CTRL_TORQUE
                    : servo_mode_pkg::CTRL_SPEED;
      end
      `MODE_EXTENSION: begin
        if (seq.torque_request) begin
          next_mode = servo_mode_pkg::CTRL_TORQUE;
        end else if (seq.position_request) begin
          next_mode = servo_mode_pkg::CTRL_POSITION;
        end else begin
          next_mode = servo_mode_pkg::CTRL_SPEED;
        end
      end
      `MODE_FIXED_POS: next_mode = servo_mode_pkg::CTRL_POSITION;
      `MODE_FIXED_SPEED: next_mode = servo_mode_pkg::CTRL_SPEED;
      `MODE_FIXED_TORQUE: next_mode = servo_mode_pkg::CTRL_TORQUE;
      default: next_mode = servo_mode_pkg::CTRL_POSITION;
    endcase
  end

  // ==========================================================
  // Pulse train gating and ratio.
  logic [RATIO_W-1:0] next_ratio;
  logic [31:0] step;
  logic [RATIO_W+7:0] step_prod;

  assign pulse_ratio_active = seq.pulse_ratio_1 | seq.pulse_ratio_2;
  assign pulse_ok = ext_mode && seq.position_request && !seq.torque_request
                    && pulse_ratio_active;
  assign next_ratio = seq.pulse_ratio_1 ? pulse_ratio_first_in
                      : pulse_ratio_second_in;
  assign step_prod = {8'h00, pulse_ratio_out} * {{(RATIO_W){1'b0}}, COUNTS_PER_PULSE};
  assign step = 32'(step_prod);

  // ==========================================================
  // Torque gating and scaling.
  logic torque_mode;
  logic next_torque_active;
  logic [23:0] torque_prod;
  logic [7:0] next_torque_pct;

  assign torque_mode = (next_mode == servo_mode_pkg::CTRL_TORQUE);
  assign next_torque_active = torque_mode && (seq.forward_command ^ seq.reverse_command);
  assign torque_prod = {8'h00, torque_reference_mv_in} * {16'h0000, `TORQUE_FULL_PCT};
  assign next_torque_pct = 8'(torque_prod / {8'h00, `TORQUE_FULL_MV});

  // ==========================================================
  // Registered outputs.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_mode_out <= servo_mode_pkg::CTRL_POSITION;
      pulse_enable_out <= 1'b0;
      pulse_positioning_out <= 1'b0;
      pulse_ratio_out <= '0;
      torque_active_out <= 1'b0;
      torque_reverse_out <= 1'b0;
      torque_percent_out <= 8'h00;
      torque_speed_limit_out <= '0;
    end else if (clk_en_in) begin
      ctrl_mode_out <= next_mode;
      pulse_enable_out <= pulse_ok;
      pulse_positioning_out <= ext_mode && seq.position_request
                               && !seq.torque_request;
      pulse_ratio_out <= next_ratio;
      torque_active_out <= next_torque_active;
      torque_reverse_out <= seq.reverse_command ^ torque_reference_neg_in;
      torque_percent_out <= next_torque_active ? next_torque_pct : 8'h00;
      torque_speed_limit_out <= torque_speed_limit_source_in ? multi_step_speed_in
                                : speed_reference_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      position_count_out <= 32'h0000_0000;
    end else if (clk_en_in && pulse_enable_out && command_pulse_in) begin
      position_count_out <= position_count_out + step;
    end
  end

  // ==========================================================
  // Override scaling of speed commands.
  override_scaler #(
    .SPEED_W(SPEED_W)
  ) u_override (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .weights_in(weights_in),
    .bits_in(seq.override_bits),
    .enable_in(seq.override_enable),
    .bypass_in(pulse_ok),
    .speed_in(speed_command_in),
    .max_speed_in(max_speed_pos_speed_mode_in),
    .clamp_in(!pulse_ok),
    .percent_out(override_percent_out),
    .speed_out(speed_out)
  );

endmodule // servo_mode_select_override

/* File: tb/servo_mode_sva.sv */
`timescale 1ns/1ps
// ========================================
// Checker on the top module ports.
module servo_mode_sva #(
  parameter int SPEED_W = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire servo_mode_pkg::seq_inputs_t seq_in,
  input wire servo_mode_pkg::seq_inputs_t assigned_in,
  input wire logic [2:0] control_mode_param_in,
  input wire logic [SPEED_W-1:0] max_speed_pos_speed_mode_in,
  input wire servo_mode_pkg::ctrl_mode_t ctrl_mode_out,
  input wire logic pulse_enable_out,
  input wire logic torque_active_out,
  input wire logic torque_reverse_out,
  input wire logic [7:0] override_percent_out,
  input wire logic [SPEED_W-1:0] speed_out
);
  servo_mode_pkg::seq_inputs_t s;
  logic [2:0] p;
  logic [1:0] up;
  assign s = seq_in & assigned_in;
  assign p = control_mode_param_in;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  fixed_mode_a: assert property (up == 2'h3 && $past(p) == 3'h0
    |-> ctrl_mode_out == servo_mode_pkg::CTRL_POSITION) else $error("fixed mode lost");
  switch_pair_a: assert property (up == 2'h3 && $past(p) == 3'h4
    && $past(s.mode_switch, 2) |-> ctrl_mode_out == servo_mode_pkg::CTRL_TORQUE)
    else $error("switch pair wrong");
  pos_hold_a: assert property (up == 2'h3 && $past(p) == 3'h6
    && $past(s.position_request && !s.torque_request, 2)
    |-> ctrl_mode_out == servo_mode_pkg::CTRL_POSITION) else $error("position not held");
  torque_hold_a: assert property (up == 2'h3 && $past(p) == 3'h6
    && $past(s.torque_request, 2) |-> ctrl_mode_out == servo_mode_pkg::CTRL_TORQUE)
    else $error("torque not held");
  pulse_gate_a: assert property (up == 2'h3 && pulse_enable_out |-> $past(p) == 3'h6
    && $past(s.position_request && (s.pulse_ratio_1 || s.pulse_ratio_2), 2))
    else $error("pulse enable without request");
  torque_gate_a: assert property (up == 2'h3 && torque_active_out
    |-> ctrl_mode_out == servo_mode_pkg::CTRL_TORQUE
    && $past(s.forward_command != s.reverse_command, 2)) else $error("torque without command");
  torque_sense_a: assert property (up == 2'h3 && torque_active_out
    |-> torque_reverse_out == $past(s.reverse_command, 2)) else $error("torque sense wrong");
  ovr_off_a: assert property (up == 2'h3 && !$past(s.override_enable, 2)
    && !pulse_enable_out |-> override_percent_out == 8'h64) else $error("override off not 100");
  speed_clamp_a: assert property (up == 2'h3 && !pulse_enable_out
    && ctrl_mode_out != servo_mode_pkg::CTRL_TORQUE
    |-> speed_out <= $past(max_speed_pos_speed_mode_in)) else $error("speed above maximum");
endmodule // servo_mode_sva

bind servo_mode_select_override servo_mode_sva #(.SPEED_W(SPEED_W)) chk (.core_clk_in,
  .rst_in, .seq_in, .assigned_in, .control_mode_param_in, .max_speed_pos_speed_mode_in,
  .ctrl_mode_out, .pulse_enable_out, .torque_active_out, .torque_reverse_out,
  .override_percent_out, .speed_out);

/* File: tb/seq_host.sv */
`timescale 1ns/1ps
// ========================================
// Host panel driving the function inputs.
module seq_host (
  input wire logic clk_in,
  input wire logic stopped_in,
  input wire servo_mode_pkg::seq_inputs_t want_in,
  output servo_mode_pkg::seq_inputs_t seq_out
);
  servo_mode_pkg::seq_inputs_t n;
  always @(negedge clk_in) begin
    n = want_in;
    if (!stopped_in) n.mode_switch = seq_out.mode_switch;
    n.pulse_ratio_1 = want_in.pulse_ratio_1 & seq_out.position_request;
    n.pulse_ratio_2 = want_in.pulse_ratio_2 & seq_out.position_request;
    seq_out <= n;
  end
endmodule // seq_host

/* File: tb/servo_mode_select_override_tb_top.sv */
`timescale 1ns/1ps
// ========================================
// Testbench.
module servo_mode_select_override_tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] param = 3'h0;
  servo_mode_pkg::seq_inputs_t want = '0, asg = '1, seq, w;
  servo_mode_pkg::override_weights_t wts = {8'h50, 8'h28, 8'h14, 8'h0A};
  logic cp = 1'b0, src = 1'b0, neg = 1'b0, en = 1'b1;
  logic [15:0] spd = 16'h0000, mv = 16'h0000, ms = 16'h0456;
  servo_mode_pkg::ctrl_mode_t mode;
  logic pe, pp, ta, tr;
  logic [7:0] ratio, tq, op;
  logic [31:0] cnt;
  logic [15:0] tsl, so;
  logic [1:0] mt [12] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2};
  int n_mismatch = 0, n_compared = 0, cyc = 0, i;
  always #12.5 core_clk_in = ~core_clk_in;
  seq_host host (.clk_in(core_clk_in), .stopped_in(so == 16'h0000), .want_in(want), .seq_out(seq));
  servo_mode_select_override uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(en),
    .seq_in(seq), .assigned_in(asg), .control_mode_param_in(param), .weights_in(wts),
    .pulse_ratio_first_in(8'h02), .pulse_ratio_second_in(8'h03), .command_pulse_in(cp),
    .speed_command_in(spd), .max_speed_pos_speed_mode_in(16'h0500),
    .torque_speed_limit_source_in(src), .speed_reference_in(16'h0123),
    .multi_step_speed_in(ms), .torque_reference_mv_in(mv), .torque_reference_neg_in(neg),
    .ctrl_mode_out(mode), .pulse_enable_out(pe), .pulse_positioning_out(pp),
    .pulse_ratio_out(ratio), .position_count_out(cnt), .torque_active_out(ta),
    .torque_reverse_out(tr), .torque_percent_out(tq), .torque_speed_limit_out(tsl),
    .override_percent_out(op), .speed_out(so));
  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic go(input servo_mode_pkg::seq_inputs_t v, input logic [2:0] p);
    @(negedge core_clk_in);
    want <= v;
    param <= p;
    repeat (5) @(negedge core_clk_in);
  endtask
  task automatic pulses(input int k);
    repeat (k) begin
      @(negedge core_clk_in);
      cp <= 1'b1;
      @(negedge core_clk_in);
      cp <= 1'b0;
    end
    repeat (3) @(negedge core_clk_in);
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(negedge core_clk_in);
    rst_in = 1'b0;
    for (i = 0; i < 12; i++) begin
      w = '0;
      w.mode_switch = i[0];
      go(w, i[3:1]);
      cmp({30'h0, mode}, {30'h0, mt[i]});
    end
    asg.mode_switch <= 1'b0;
    go(w, 3'h3);
    cmp({30'h0, mode}, 32'h0);
    asg <= '1;
    w = '0;
    w.position_request = 1'b1;
    w.pulse_ratio_1 = 1'b1;
    w.override_enable = 1'b1;
    w.override_bits = 4'h1;
    go(w, 3'h6);
    cmp({29'h0, mode, pe}, 32'h1);
    cmp({31'h0, pp}, 32'h1);
    cmp({24'h0, ratio}, 32'h02);
    cmp({24'h0, op}, 32'h64);
    pulses(3);
    cmp(cnt, 32'h60);
    en <= 1'b0;
    pulses(2);
    cmp(cnt, 32'h60);
    en <= 1'b1;
    w.pulse_ratio_1 = 1'b0;
    w.pulse_ratio_2 = 1'b1;
    go(w, 3'h6);
    pulses(2);
    cmp(cnt, 32'hC0);
    w.pulse_ratio_1 = 1'b1;
    go(w, 3'h6);
    pulses(1);
    cmp(cnt, 32'hE0);
    go(w, 3'h3);
    pulses(1);
    cmp({31'h0, pe}, 32'h0);
    cmp(cnt, 32'hE0);
    w = '0;
    w.torque_request = 1'b1;
    mv <= 16'h0BB8;
    go(w, 3'h6);
    cmp({29'h0, mode, ta}, 32'h4);
    w.forward_command = 1'b1;
    go(w, 3'h6);
    cmp({30'h0, ta, tr}, 32'h2);
    cmp({24'h0, tq}, 32'h64);
    w.forward_command = 1'b0;
    w.reverse_command = 1'b1;
    mv <= 16'h05DC;
    go(w, 3'h6);
    cmp({30'h0, ta, tr}, 32'h3);
    cmp({24'h0, tq}, 32'h32);
    w.forward_command = 1'b1;
    src <= 1'b1;
    go(w, 3'h6);
    cmp({31'h0, ta}, 32'h0);
    cmp({24'h0, tq}, 32'h00);
    cmp({16'h0, tsl}, {16'h0, ms});
    src <= 1'b0;
    go(w, 3'h6);
    cmp({16'h0, tsl}, 32'h0123);
    w = '0;
    spd <= 16'h03E8;
    go(w, 3'h1);
    cmp({8'h0, op, so}, 32'h006403E8);
    w.override_enable = 1'b1;
    w.override_bits = 4'h5;
    go(w, 3'h1);
    cmp({8'h0, op, so}, 32'h003201F4);
    w.override_bits = 4'hF;
    go(w, 3'h1);
    cmp({8'h0, op, so}, 32'h00960500);
    wts.w3 <= 8'h96;
    go(w, 3'h1);
    cmp({24'h0, op}, 32'h96);
    wts <= {8'h50, 8'h28, 8'h14, 8'h05};
    w.override_bits = 4'h1;
    go(w, 3'h1);
    cmp({24'h0, op}, 32'h05);
    end_sim();
  end
endmodule // servo_mode_select_override_tb_top
